// ### common/scs_pkg.sv
// Package: register map, field layout and timing constants of the conversion sequencer
package scs_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL0 = 8'h00; // conv_ctrl_reg0: busy, done flag, continuous bit
  localparam logic [7:0] REG_CTRL1 = 8'h04; // conv_ctrl_reg1: divider select
  localparam logic [7:0] REG_RESULT_LOW = 8'h08; // result_low_start_reg: write starts conversion
  localparam logic [7:0] REG_RESULT_HIGH = 8'h0C; // Upper result bits
  localparam logic [7:0] REG_STATUS = 8'h10; // Calibration status
  // conv_ctrl_reg0 fields
  localparam int CTRL0_BUSY_BIT = 0;
  localparam int CTRL0_DONE_BIT = 1;
  localparam int CTRL0_CONT_BIT = 2;
  // conv_ctrl_reg1 fields
  localparam int CTRL1_DIV_LO_BIT = 0;
  localparam logic [1:0] DIV_SEL_RESET = 2'h1;
  // Status fields
  localparam int STATUS_CAL_DONE_BIT = 0;
  // Timing
  localparam int OSC_PER_MACHINE_CYCLE = 12;
  localparam int IN_CLK_PER_MACHINE_CYCLE = 6;
  localparam int CLK_PER_MACHINE_CYCLE = 12;
  localparam int RESULT_BITS = 10;
  localparam int RESET_CAL_CONV_CLOCKS = 3328;
  localparam int IRQ_HANDLER_DELAY_MC = 3;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SCS_IDLE = 2'b00,
    SCS_CONVERT = 2'b01,
    SCS_WRITE = 2'b10
  } scs_state_t;
endpackage

// ### hdl/scs_sequencer.sv
// Conversion sequencer: AXI4-Lite registers, SAR sequencing and calibration engine
`timescale 1ns/1ps
module scs_sequencer
  import scs_pkg::*;
#(
  parameter int CAL_CLOCKS = RESET_CAL_CONV_CLOCKS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compIn,
  output logic [RESULT_BITS-1:0] sarTrial,
  output logic convDoneIrq,
  output logic machineCycleStrobe
);

  // Cycle count of a conversion in machine cycles for a given divider select
  function automatic logic [6:0] conv_cycles(input logic [1:0] sel);
    conv_cycles = 7'(8 << sel);
  endfunction

  // Conversion clock divide count in clk cycles (clk stands for the oscillator)
  function automatic logic [5:0] div_count(input logic [1:0] sel);
    div_count = 6'(4 << sel);
  endfunction

  logic [7:0] awAddr;
  logic awHeld;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wHeld;
  logic doWrite;
  logic [1:0] divSel;
  logic contMode;
  logic busyFlag;
  logic doneFlag;
  logic [RESULT_BITS-1:0] result;
  logic startPending;
  logic [3:0] mcCount;
  logic mcTick;
  logic [5:0] adcCount;
  logic adcTick;
  scs_state_t state;
  logic [6:0] phaseCount;
  logic [RESULT_BITS-1:0] sarReg;
  logic [3:0] bitIdx;
  logic [11:0] calCount;
  logic calDone;
  logic calSel;
  logic [1:0] calAddr;
  logic [7:0] calRam [4];
  logic [1:0] irqDelay;

  // Write channels taken independently, in either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr == REG_CTRL0 || awAddr == REG_CTRL1 || awAddr == REG_RESULT_LOW) ?
          AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel, one outstanding read
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= AXI_OKAY;
      unique case (s_axi_araddr[7:0])
        REG_CTRL0: s_axi_rdata <= {29'h0, contMode, doneFlag, busyFlag};
        REG_CTRL1: s_axi_rdata <= {30'h0, divSel};
        REG_RESULT_LOW: s_axi_rdata <= {24'h0, result[7:0]};
        REG_RESULT_HIGH: s_axi_rdata <= {30'h0, result[9:8]};
        REG_STATUS: s_axi_rdata <= {31'h0, calDone}; // Only completion shows, never cal data
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Machine cycle tick: twelve clk periods, six input clock periods
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mcCount <= 4'h0;
    end else begin
      mcCount <= (mcCount == 4'(CLK_PER_MACHINE_CYCLE - 1)) ? 4'h0 : mcCount + 4'h1;
    end
  end
  assign mcTick = (mcCount == 4'(CLK_PER_MACHINE_CYCLE - 1));
  assign machineCycleStrobe = mcTick;

  // Conversion clock enable from the prescaler
  always_ff @(posedge clk) begin
    if (!rstn) begin
      adcCount <= 6'h00;
    end else begin
      adcCount <= (adcCount >= div_count(divSel) - 6'h01) ? 6'h00 : adcCount + 6'h01;
    end
  end
  assign adcTick = (adcCount >= div_count(divSel) - 6'h01);

  // Software control bits; software alone clears the done flag
  always_ff @(posedge clk) begin
    if (!rstn) begin
      divSel <= DIV_SEL_RESET;
      contMode <= 1'b0;
    end else if (doWrite) begin
      if (awAddr == REG_CTRL1 && wStrb[0]) begin
        divSel <= wData[CTRL1_DIV_LO_BIT +: 2];
      end
      if (awAddr == REG_CTRL0 && wStrb[0]) begin
        contMode <= wData[CTRL0_CONT_BIT];
      end
    end
  end

  // Start latch: held until the next machine-cycle boundary
  always_ff @(posedge clk) begin
    if (!rstn) begin
      startPending <= 1'b0;
    end else if (doWrite && awAddr == REG_RESULT_LOW) begin
      startPending <= 1'b1;
    end else if (mcTick) begin
      startPending <= 1'b0;
    end
  end

  // Conversion sequence on machine cycle boundaries
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= SCS_IDLE;
      phaseCount <= 7'h00;
      busyFlag <= 1'b0;
    end else if (mcTick) begin
      if (startPending) begin
        state <= SCS_CONVERT;
        phaseCount <= 7'h01;
        busyFlag <= 1'b1;
      end else begin
        unique case (state)
          SCS_IDLE: begin
            busyFlag <= 1'b0;
          end
          SCS_CONVERT: begin
            if (phaseCount == conv_cycles(divSel)) begin
              state <= SCS_WRITE;
              busyFlag <= 1'b0;
            end else begin
              phaseCount <= phaseCount + 7'h01;
            end
          end
          SCS_WRITE: begin
            if (contMode) begin
              state <= SCS_CONVERT;
              phaseCount <= 7'h01;
              busyFlag <= 1'b1;
            end else begin
              state <= SCS_IDLE;
            end
          end
          default: begin
            state <= SCS_IDLE;
          end
        endcase
      end
    end
  end

  // Done flag: set at conversion end, set wins over a software clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      doneFlag <= 1'b0;
    end else if (mcTick && !startPending && state == SCS_CONVERT && phaseCount == conv_cycles(divSel)) begin
      doneFlag <= 1'b1;
    end else if (doWrite && awAddr == REG_CTRL0 && wStrb[0] && !wData[CTRL0_DONE_BIT]) begin
      doneFlag <= 1'b0;
    end
  end

  // Successive approximation, one trial bit per conversion clock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sarReg <= '0;
      bitIdx <= 4'h0;
    end else if (mcTick && (startPending || (state == SCS_WRITE && contMode))) begin
      sarReg <= '0;
      bitIdx <= 4'(RESULT_BITS);
    end else if (state == SCS_CONVERT && adcTick && bitIdx != 4'h0) begin
      sarReg[bitIdx - 4'h1] <= compIn;
      bitIdx <= bitIdx - 4'h1;
    end
  end
  // Trial word: settled bits plus the bit now under test
  assign sarTrial = (bitIdx != 4'h0) ? (sarReg | (10'h001 << (bitIdx - 4'h1))) : sarReg;

  // Result load in the write-result cycle, readable at once
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result <= '0;
    end else if (mcTick && !startPending && state == SCS_CONVERT && phaseCount == conv_cycles(divSel)) begin
      result <= sarReg;
    end
  end

  // Calibration engine: reset calibration counts in idle only, RAM nudging goes on during conversions
  always_ff @(posedge clk) begin
    if (!rstn) begin
      calCount <= 12'h000;
      calDone <= 1'b0;
      calSel <= 1'b0;
    end else if (adcTick) begin
      if (!calDone && state == SCS_IDLE) begin
        calSel <= !calSel;
        if (calCount == 12'(CAL_CLOCKS - 1)) begin
          calDone <= 1'b1;
        end else begin
          calCount <= calCount + 12'h001;
        end
      end else if (state == SCS_CONVERT) begin
        calSel <= !calSel;
      end
    end
  end

  // Calibration RAM: offset in even words, linearity in odd words
  assign calAddr = {calCount[0], calSel};
  always_ff @(posedge clk) begin
    if (!rstn) begin
      calRam[0] <= 8'h00;
      calRam[1] <= 8'h00;
      calRam[2] <= 8'h00;
      calRam[3] <= 8'h00;
    end else if (adcTick && (state == SCS_CONVERT || (!calDone && state == SCS_IDLE))) begin
      // Nudge toward the comparator verdict; no register reaches this
      if (compIn && calRam[calAddr] != 8'hFF) begin
        calRam[calAddr] <= calRam[calAddr] + 8'h01;
      end else if (!compIn && calRam[calAddr] != 8'h00) begin
        calRam[calAddr] <= calRam[calAddr] - 8'h01;
      end
    end
  end

  // Interrupt line to the core's controller, mirrors the done flag
  assign convDoneIrq = doneFlag;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irqDelay <= 2'h0;
    end else if (mcTick) begin
      irqDelay <= (state == SCS_WRITE) ? 2'h1 : ((irqDelay != 2'h0 && irqDelay != 2'h3) ? irqDelay + 2'h1 : 2'h0);
    end
  end

  property p_done_on_end;
    @(posedge clk) disable iff (!rstn)
      (mcTick && !startPending && state == SCS_CONVERT && phaseCount == conv_cycles(divSel))
        |=> (doneFlag && !busyFlag && state == SCS_WRITE);
  endproperty
  a_done_on_end: assert property (p_done_on_end) else $error("done flag not set at end");

  property p_busy_start;
    @(posedge clk) disable iff (!rstn) (mcTick && startPending) |=> (busyFlag && phaseCount == 7'h01);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not set at start");

  property p_write_one_cycle;
    @(posedge clk) disable iff (!rstn)
      (mcTick && state == SCS_WRITE && contMode && !startPending) |=> (busyFlag && state == SCS_CONVERT);
  endproperty
  a_write_one_cycle: assert property (p_write_one_cycle) else $error("continuous restart missing");

  property p_done_sticky;
    @(posedge clk) disable iff (!rstn) (doneFlag && !doWrite) |=> doneFlag;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag dropped");

  property p_result_load;
    @(posedge clk) disable iff (!rstn) (state == SCS_WRITE) |-> (result == sarReg);
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded");

  property p_length;
    @(posedge clk) disable iff (!rstn) (state == SCS_CONVERT) |-> (phaseCount <= conv_cycles(divSel));
  endproperty
  a_length: assert property (p_length) else $error("conversion overrun");

  property p_mc;
    // Eleven quiet clocks split as eight repeated plus three single steps
    @(posedge clk) disable iff (!rstn)
      mcTick |=> !mcTick [*8] ##1 !mcTick ##1 !mcTick ##1 !mcTick ##1 mcTick;
  endproperty
  a_mc: assert property (p_mc) else $error("machine cycle not twelve clocks");

  property p_stop;
    @(posedge clk) disable iff (!rstn)
      (mcTick && state == SCS_WRITE && !contMode && !startPending) |=> (state == SCS_IDLE && !busyFlag);
  endproperty
  a_stop: assert property (p_stop) else $error("conversion restarted without continuous");

endmodule

// ### bench/scs_comp_model.sv
// Comparator model standing for the sampled input and capacitor network
`timescale 1ns/1ps
module scs_comp_model
  import scs_pkg::*;
(
  input wire logic [RESULT_BITS-1:0] sarTrial,
  input wire logic [RESULT_BITS-1:0] level,
  output logic compIn
);
  // Ideal verdict, so a correct sequencer must return the held level exactly
  assign compIn = (level >= sarTrial);
endmodule

// ### bench/scs_sequencer_tb_top.sv
// Self-checking bench: register bus, conversion timing and results
`timescale 1ns/1ps
module scs_sequencer_tb_top
  import scs_pkg::*;
;
  logic clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, compIn, convDoneIrq, mcStrobe;
  logic [31:0] awaddr, wdata, araddr, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [RESULT_BITS-1:0] sarTrial, level;
  int errTotal, compares, n;
  // Behavioural model: expected result per conversion that runs to completion
  logic [RESULT_BITS-1:0] expQ [$];

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Short calibration keeps the run brief
  scs_sequencer #(.CAL_CLOCKS(16)) u_scs_sequencer (
    .clk(clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .compIn(compIn), .sarTrial(sarTrial), .convDoneIrq(convDoneIrq), .machineCycleStrobe(mcStrobe)
  );

  scs_comp_model u_scs_comp_model (.sarTrial(sarTrial), .level(level), .compIn(compIn));

  task automatic chkReg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chkRange(input string nm, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      errTotal++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // Ready is combinational of registers, so its value at the falling edge holds at the next rise
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ta, tw, aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(negedge clk);
      ta = awready & !aw;
      tw = wready & !w;
      @(posedge clk);
      if (ta) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (tw) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(negedge clk);
      ta = bvalid;
      rs = bresp;
      @(posedge clk);
    end while (ta !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic t;
    @(posedge clk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end while (t !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      t = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge clk);
    end while (t !== 1'b1);
    rready <= 1'b0;
  endtask

  // Counts machine-cycle ends until the done flag rises
  task automatic waitDone(output int mc);
    int k;
    mc = 0;
    k = 0;
    while (convDoneIrq !== 1'b1 && k < 2000) begin
      @(negedge clk);
      if (mcStrobe === 1'b1) mc++;
      k++;
    end
    // A wait that runs out is a failure in itself
    if (k >= 2000) errTotal++;
  endtask

  // One conversion; the expected result is the level the model holds
  task automatic convOnce(input int d, input logic cont, input logic again);
    int mc;
    logic [RESULT_BITS-1:0] lv;
    logic [RESULT_BITS-1:0] ex;
    lv = RESULT_BITS'($urandom);
    expQ.push_back(lv);
    @(posedge clk);
    level <= lv;
    axiWrite(REG_CTRL1, 32'(d), r);
    axiRead(REG_CTRL1, v, r);
    chkReg("divider", 32'(d), v);
    axiWrite(REG_CTRL0, {29'h0, cont, 2'h0}, r);
    axiWrite(REG_RESULT_LOW, 32'(lv), r);
    chkReg("start resp", 32'(AXI_OKAY), 32'(r));
    if (again) begin
      repeat (40) @(posedge clk);
      lv = ~lv;
      level <= lv;
      // Abandoned conversion leaves no result behind
      ex = expQ.pop_back();
      expQ.push_back(lv);
      axiWrite(REG_RESULT_LOW, 32'h0, r);
    end
    waitDone(mc);
    axiRead(REG_CTRL0, v, r);
    chkReg("ctrl0 at write", {29'h0, cont, 2'b10}, v);
    ex = expQ.pop_front();
    axiRead(REG_RESULT_LOW, v, r);
    chkReg("result low", 32'(ex[7:0]), v);
    axiRead(REG_RESULT_HIGH, v, r);
    chkReg("result high", 32'(ex[9:8]), v);
    chkRange("conv cycles", 8 << d, (8 << d) + 1, mc);
    if (cont) begin
      repeat (2) @(posedge mcStrobe);
      axiRead(REG_CTRL0, v, r);
      chkReg("busy again", 32'h7, v);
      axiWrite(REG_CTRL0, 32'h0, r);
      // Waits on the done flag, since polling busy can miss its one low cycle
      waitDone(mc);
      chkRange("last conv", 1, (8 << d) + 1, mc);
      repeat ((9 << d) * 12) @(posedge clk);
      axiRead(REG_CTRL0, v, r);
      chkReg("stopped", 32'h2, v);
    end else begin
      repeat (50) @(posedge clk);
      chkReg("done held", 32'h1, 32'(convDoneIrq));
      axiWrite(REG_CTRL0, 32'h2, r);
      axiRead(REG_CTRL0, v, r);
      chkReg("done kept", 32'h2, v);
    end
    $display("test conv div %0d cont %0b restart %0b done", d, cont, again);
  endtask

  task automatic endOfTest();
    $display("compares %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog well beyond the longest expected run
  initial begin
    repeat (50000) @(posedge clk);
    errTotal++;
    endOfTest();
  end

  // Main sequence
  initial begin
    errTotal = 0;
    compares = 0;
    rstn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    level = '0;
    void'($urandom(61));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, calibration still running
    for (int i = 0; i < 5; i++) begin
      axiRead(8'(4 * i), v, r);
      chkReg("reset value", (i == 1) ? 32'h1 : 32'h0, v);
    end
    $display("test reset values done");
    n = 0;
    while (mcStrobe !== 1'b1) @(negedge clk);
    do begin
      @(negedge clk);
      n++;
    end while (mcStrobe !== 1'b1 && n < 100);
    chkRange("mc length", 12, 12, n);
    // Software waits for calibration before converting
    n = 0;
    do begin
      axiRead(REG_STATUS, v, r);
      n++;
    end while (v[0] !== 1'b1 && n < 200);
    chkReg("cal done", 32'h1, v);
    axiRead(8'h14, v, r);
    chkReg("unmapped resp", 32'(AXI_SLVERR), 32'(r));
    chkReg("unmapped data", 32'h0, v);
    axiWrite(REG_STATUS, 32'h0, r);
    chkReg("ro write resp", 32'(AXI_SLVERR), 32'(r));
    axiRead(REG_STATUS, v, r);
    chkReg("status kept", 32'h1, v);
    $display("test refusals done");
    for (int d = 0; d < 4; d++) convOnce(d, 1'b0, 1'b0);
    convOnce(0, 1'b0, 1'b1);
    convOnce(1, 1'b1, 1'b0);
    endOfTest();
  end
endmodule
